// ==== design/cbh_bus_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "cbh_map.svh"
module cbh_bus_ctrl #(
	parameter int ADDR_W = `CBH_ADDR_W,
	parameter int DATA_W = `CBH_DATA_W
) (
	input wire logic core_clk_in,
	input wire logic arst_n_in,
	// pins from the system
	input wire logic phase1_in,
	input wire logic phase2_in,
	input wire logic halt_n_in,
	input wire logic bus_float_control_in,
	input wire logic data_drive_enable_in,
	input wire logic irq_n_in,
	// pins to the system, and the data lines back from it
	output logic [ADDR_W-1:0] address_lines_out,
	output logic address_lines_oe_out,
	input wire logic [DATA_W-1:0] data_lines_in,
	output logic [DATA_W-1:0] data_lines_out,
	output logic data_lines_oe_out,
	output logic read_write_out,
	output logic read_write_oe_out,
	output logic valid_address_strobe_out,
	output logic bus_released_out,
	// core side
	input wire logic core_access_in,
	input wire logic core_write_in,
	input wire logic [ADDR_W-1:0] core_addr_in,
	input wire logic [DATA_W-1:0] core_wdata_in,
	input wire logic core_instr_end_in,
	input wire logic core_irq_ack_in,
	output logic core_stall_out,
	output logic [DATA_W-1:0] core_rdata_out,
	output logic core_irq_out,
	output cbh_pkg::cbh_state_t bus_state_out,
	output logic halt_setup_err_out,
	output logic float_overstay_out
);
	import cbh_pkg::*;

	// ----------------------------------------
	// constants
	// ----------------------------------------
	localparam int SETUP_CYC = `CBH_HALT_SETUP_CYC; // halt quiet time before phase one ends
	localparam int FLOAT_CYC = `CBH_FLOAT_MAX_CYC; // longest floated stretch
	localparam int CNT_W = $clog2(FLOAT_CYC + 1);
	localparam logic [CNT_W-1:0] SETUP_LIM = CNT_W'(SETUP_CYC);
	localparam logic [CNT_W-1:0] FLOAT_LIM = CNT_W'(FLOAT_CYC);

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [`CBH_SYNC_W-1:0] pins_raw; // all asynchronous pins, packed
	logic [`CBH_SYNC_W-1:0] pins_s; // same pins after two flops
	// active-low pins go in inverted so the flops' reset zero reads as idle, not as a request
	assign pins_raw = {data_lines_in, ~irq_n_in, data_drive_enable_in, bus_float_control_in,
		~halt_n_in, phase2_in, phase1_in};

	// data pins are only used at a phase two edge, so skew across bits has settled by then
	cbh_sync #(
		.WIDTH(`CBH_SYNC_W)
	) u_sync (
		.core_clk_in(core_clk_in),
		.arst_n_in(arst_n_in),
		.async_in(pins_raw),
		.sync_out(pins_s)
	);

	logic p1_s, p2_s, halt_s, float_s, dbe_s, irq_s; // synchronised levels
	logic [DATA_W-1:0] din_s; // synchronised data pins
	assign p1_s = pins_s[`CBH_SB_P1];
	assign p2_s = pins_s[`CBH_SB_P2];
	assign halt_s = ~pins_s[`CBH_SB_HALT];
	assign float_s = pins_s[`CBH_SB_FLOAT];
	assign dbe_s = pins_s[`CBH_SB_DBE];
	assign irq_s = pins_s[`CBH_SB_IRQ];
	assign din_s = pins_s[`CBH_SB_DATA +: DATA_W];

	// ----------------------------------------
	// phase edge detection
	// ----------------------------------------
	logic p1_d, p2_d, next_p1_d, next_p2_d; // previous phase levels
	logic p1_rise, p1_fall, p2_fall; // one-cycle edge pulses
	always_comb begin
		next_p1_d = p1_s;
		next_p2_d = p2_s;
	end
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			p1_d <= 1'b0;
			p2_d <= 1'b0;
		end else begin
			p1_d <= next_p1_d;
			p2_d <= next_p2_d;
		end
	end
	assign p1_rise = p1_s & ~p1_d;
	assign p1_fall = ~p1_s & p1_d;
	assign p2_fall = ~p2_s & p2_d;

	// ----------------------------------------
	// halt sampling and setup check
	// ----------------------------------------
	logic halt_smp, next_halt_smp; // halt as taken at the end of phase one
	logic halt_prev, next_halt_prev; // halt one cycle ago
	logic [CNT_W-1:0] quiet_cnt, next_quiet_cnt; // cycles since halt last moved
	logic next_setup_err;
	// sampling at the phase one fall gives the whole quiet window as margin
	always_comb begin
		next_halt_prev = halt_s;
		next_halt_smp = halt_smp;
		next_quiet_cnt = quiet_cnt;
		next_setup_err = 1'b0;
		if (halt_s != halt_prev) begin
			next_quiet_cnt = '0;
		end else if (quiet_cnt < SETUP_LIM) begin
			next_quiet_cnt = quiet_cnt + CNT_W'(1);
		end
		if (p1_fall) begin
			next_halt_smp = halt_s;
			next_setup_err = (quiet_cnt < SETUP_LIM);
		end
	end
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			halt_smp <= 1'b1;
			halt_prev <= 1'b1;
			quiet_cnt <= '0;
			halt_setup_err_out <= 1'b0;
		end else begin
			halt_smp <= next_halt_smp;
			halt_prev <= next_halt_prev;
			quiet_cnt <= next_quiet_cnt;
			halt_setup_err_out <= next_setup_err;
		end
	end

	// ----------------------------------------
	// float stretch watchdog
	// ----------------------------------------
	logic [CNT_W-1:0] float_cnt, next_float_cnt; // cycles spent floated
	logic next_overstay;
	// the device cannot shorten the stretch, it can only report it for the system to see
	always_comb begin
		next_float_cnt = '0;
		next_overstay = float_overstay_out;
		if (float_s) begin
			next_float_cnt = (float_cnt < FLOAT_LIM) ? float_cnt + CNT_W'(1) : float_cnt;
			if (float_cnt >= FLOAT_LIM) begin
				next_overstay = 1'b1;
			end
		end else begin
			next_overstay = 1'b0;
		end
	end
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			float_cnt <= '0;
			float_overstay_out <= 1'b0;
		end else begin
			float_cnt <= next_float_cnt;
			float_overstay_out <= next_overstay;
		end
	end

	// ----------------------------------------
	// halt state machine
	// ----------------------------------------
	cbh_state_t state, next_state; // bus ownership
	always_comb begin
		next_state = state;
		case (state)
			CBH_RUN: begin
				if (!halt_smp) begin
					// an instruction ending right now halts at once
					next_state = core_instr_end_in ? CBH_HALTED : CBH_DRAIN;
				end
			end
			CBH_DRAIN: begin
				if (halt_smp) begin
					next_state = CBH_RUN;
				end else if (core_instr_end_in) begin
					next_state = CBH_HALTED;
				end
			end
			CBH_HALTED: begin
				// a single high sample lets one instruction run before halting again
				if (halt_smp) begin
					next_state = CBH_RUN;
				end
			end
			default: begin
				next_state = CBH_RUN;
			end
		endcase
	end
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state <= CBH_RUN;
		end else begin
			state <= next_state;
		end
	end
	assign bus_state_out = state;

	logic halted; // bus handed over
	assign halted = (state == CBH_HALTED);
	// core waits while halted or while the clock is stretched for a float
	assign core_stall_out = halted | float_s;

	// ----------------------------------------
	// bus cycle registers
	// ----------------------------------------
	logic [ADDR_W-1:0] addr_q, next_addr_q; // address on the pins
	logic [DATA_W-1:0] wdata_q, next_wdata_q; // write data on the pins
	logic [DATA_W-1:0] next_rdata; // captured read data
	logic rw_q, next_rw_q; // direction, high is read
	logic vma_q, next_vma_q; // address valid
	// a new cycle starts on each phase one rise while the core is free to run
	always_comb begin
		next_addr_q = addr_q;
		next_wdata_q = wdata_q;
		next_rw_q = rw_q;
		next_vma_q = vma_q;
		next_rdata = core_rdata_out;
		if (halted) begin
			next_vma_q = 1'b0;
			next_rw_q = `CBH_RW_IDLE;
		end else if (p1_rise && !float_s) begin
			next_addr_q = core_addr_in;
			next_vma_q = core_access_in;
			next_rw_q = core_access_in ? ~core_write_in : `CBH_RW_IDLE;
			next_wdata_q = core_wdata_in;
		end
		if (p2_fall && vma_q && rw_q) begin
			next_rdata = din_s;
		end
	end
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			addr_q <= `CBH_ADDR_RST;
			wdata_q <= `CBH_DATA_RST;
			rw_q <= `CBH_RW_IDLE;
			vma_q <= 1'b0;
			core_rdata_out <= `CBH_DATA_RST;
		end else begin
			addr_q <= next_addr_q;
			wdata_q <= next_wdata_q;
			rw_q <= next_rw_q;
			vma_q <= next_vma_q;
			core_rdata_out <= next_rdata;
		end
	end

	// ----------------------------------------
	// pin drive
	// ----------------------------------------
	// float is a level here, so drivers come back as soon as it drops
	assign address_lines_out = addr_q;
	assign address_lines_oe_out = ~float_s & ~halted;
	assign read_write_out = rw_q;
	assign read_write_oe_out = ~float_s & ~halted;
	assign valid_address_strobe_out = vma_q & ~float_s & ~halted;
	assign bus_released_out = halted & ~float_s;
	// float plays no part here; read cycles keep the drivers off
	assign data_lines_out = wdata_q;
	assign data_lines_oe_out = dbe_s & vma_q & ~rw_q & ~halted;

	// ----------------------------------------
	// interrupt latch across halt
	// ----------------------------------------
	logic irq_held, next_irq_held; // request seen while halted
	// set only while halted and clear only on an acknowledge while running, so the two never meet in one cycle
	always_comb begin
		next_irq_held = irq_held;
		if (!halted && core_irq_ack_in) begin
			next_irq_held = 1'b0;
		end
		if (halted && irq_s) begin
			next_irq_held = 1'b1;
		end
	end
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			irq_held <= 1'b0;
		end else begin
			irq_held <= next_irq_held;
		end
	end
	assign core_irq_out = (irq_held | irq_s) & ~halted;
endmodule // cbh_bus_ctrl
`default_nettype wire

// ==== common/cbh_map.svh ====
`ifndef CBH_MAP_SVH
`define CBH_MAP_SVH
// ----------------------------------------
// clock and timing figures
// ----------------------------------------
`define CBH_CLK_MHZ 40
`define CBH_HALT_SETUP_NS 250
`define CBH_FLOAT_MAX_NS 4500
// least time, rounded up to whole cycles
`define CBH_HALT_SETUP_CYC ((`CBH_HALT_SETUP_NS * `CBH_CLK_MHZ + 999) / 1000)
// longest time, rounded down to whole cycles
`define CBH_FLOAT_MAX_CYC ((`CBH_FLOAT_MAX_NS * `CBH_CLK_MHZ) / 1000)
// ----------------------------------------
// widths, positions and reset values
// ----------------------------------------
`define CBH_ADDR_W 16
`define CBH_DATA_W 8
`define CBH_SYNC_W 14
`define CBH_SB_P1 0
`define CBH_SB_P2 1
`define CBH_SB_HALT 2
`define CBH_SB_FLOAT 3
`define CBH_SB_DBE 4
`define CBH_SB_IRQ 5
`define CBH_SB_DATA 6
`define CBH_RW_IDLE 1'b1
`define CBH_ADDR_RST 16'h0000
`define CBH_DATA_RST 8'h00
`endif

// ==== common/cbh_pkg.sv ====
package cbh_pkg;
	// bus ownership state, gray coded along run -> drain -> halted
	typedef enum logic [1:0] {
		CBH_RUN = 2'b00,
		CBH_DRAIN = 2'b01,
		CBH_HALTED = 2'b11
	} cbh_state_t;
endpackage

// ==== design/cbh_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// two flip-flop synchroniser, one stage pair per bit
// ----------------------------------------
module cbh_sync #(
	parameter int WIDTH = 1
) (
	input wire logic core_clk_in,
	input wire logic arst_n_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_bit
			logic meta; // first stage, read only by the second
			logic stable; // second stage
			// the first stage may go metastable, so nothing but stage two looks at it
			always_ff @(posedge core_clk_in or negedge arst_n_in) begin
				if (!arst_n_in) begin
					meta <= 1'b0;
					stable <= 1'b0;
				end else begin
					meta <= async_in[gi];
					stable <= meta;
				end
			end
			assign sync_out[gi] = stable;
		end
	endgenerate
endmodule // cbh_sync
`default_nettype wire

// ==== sim/cbh_bus_ctrl_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// bus pin checker
// ----------------------------------------
module cbh_bus_ctrl_properties (
	input wire logic core_clk_in,
	input wire logic arst_n_in,
	input wire logic bus_float_control_in,
	input wire logic data_drive_enable_in,
	input wire logic core_instr_end_in,
	input wire logic address_lines_oe_out,
	input wire logic data_lines_oe_out,
	input wire logic read_write_oe_out,
	input wire logic valid_address_strobe_out,
	input wire logic bus_released_out,
	input wire logic core_stall_out,
	input wire cbh_pkg::cbh_state_t bus_state_out
);
	import cbh_pkg::*;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!arst_n_in);
	// four samples cover the two synchroniser flops with margin
	sequence float_held;
		bus_float_control_in [*4];
	endsequence
	sequence float_clear;
		!bus_float_control_in [*4];
	endsequence
	sequence halted_two;
		(bus_state_out == CBH_HALTED) [*2];
	endsequence
	float_off_a: assert property (float_held |-> !address_lines_oe_out && !read_write_oe_out)
		else $error("address or direction driven while floated");
	float_quiet_a: assert property (float_held |-> !valid_address_strobe_out && !bus_released_out)
		else $error("strobe or released high while floated");
	halt_pins_a: assert property (float_clear ##0 halted_two |-> bus_released_out &&
		!valid_address_strobe_out && !address_lines_oe_out && !read_write_oe_out && !data_lines_oe_out)
		else $error("halted pins wrong");
	halt_stall_a: assert property (bus_state_out == CBH_HALTED |-> core_stall_out)
		else $error("core not stalled while halted");
	drain_wait_a: assert property (bus_state_out == CBH_DRAIN && !core_instr_end_in |=>
		bus_state_out != CBH_HALTED) else $error("halted before instruction end");
	run_release_a: assert property ((bus_state_out == CBH_RUN) [*2] |-> !bus_released_out)
		else $error("released high while running");
	float_back_a: assert property (float_clear ##0 (bus_state_out == CBH_RUN) [*2] |->
		address_lines_oe_out && read_write_oe_out) else $error("drivers off while running");
	strobe_addr_a: assert property (valid_address_strobe_out |-> address_lines_oe_out)
		else $error("strobe without driven address");
	drive_gate_a: assert property (!data_drive_enable_in [*5] |-> !data_lines_oe_out)
		else $error("data driven without drive enable");
endmodule // cbh_bus_ctrl_properties
bind cbh_bus_ctrl cbh_bus_ctrl_properties u_props (.*);
`default_nettype wire

// ==== sim/cbh_sys_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// clock source, drive enable and memory
// ----------------------------------------
module cbh_sys_model (
	input wire logic core_clk_in,
	input wire logic float_req_in,
	input wire logic [15:0] addr_in,
	input wire logic addr_oe_in,
	input wire logic rw_in,
	output logic phase1_out,
	output logic phase2_out,
	output logic drv_en_out,
	output logic [7:0] data_out
);
	logic [5:0] tick; // position in the 40 cycle bus period
	initial begin
		tick = 6'h00;
		phase1_out = 1'b0;
		phase2_out = 1'b0;
		drv_en_out = 1'b0;
		data_out = 8'h00;
	end
	// phases change off the sampling edge; one stays high while floated
	always @(negedge core_clk_in) begin
		if (!(float_req_in && tick == 6'h10)) begin
			tick <= (tick == 6'h27) ? 6'h00 : tick + 6'h01;
		end
		phase1_out <= tick < 6'h12;
		phase2_out <= tick >= 6'h14 && tick < 6'h26;
		drv_en_out <= tick >= 6'h14 && tick < 6'h26;
		// memory drives reads; a released line keeps changing
		if (rw_in && addr_oe_in && tick >= 6'h14) begin
			data_out <= ~addr_in[7:0] ^ addr_in[15:8];
		end else begin
			data_out <= ~data_out;
		end
	end
endmodule // cbh_sys_model
`default_nettype wire

// ==== sim/cbh_bus_ctrl_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module cbh_bus_ctrl_tb;
	import cbh_pkg::*;
	typedef struct packed {logic acc; logic wr; logic [15:0] a; logic [7:0] d;} cbh_row_t;
	logic clk, rst_n, ph1, ph2, halt_n, float_req, drv_en, irq_n, acc, wr, iend, iack;
	logic addr_oe, dout_oe, rw, rw_oe, strobe, released, stall, cirq, serr, over;
	logic [15:0] addr, caddr;
	logic [7:0] din, dout, cwdata, rdata;
	cbh_state_t st;
	int err_count = 0;
	int comparisons = 0;
	int hits = 0; // setup error pulses seen
	// ordinary cycles: idle, writes and reads at edge addresses, one read at 1234
	cbh_row_t rows[5] = '{'{1'b0, 1'b0, 16'h0000, 8'h00}, '{1'b1, 1'b1, 16'hFFFF, 8'h5A},
		'{1'b1, 1'b0, 16'h1234, 8'h00}, '{1'b1, 1'b1, 16'h8001, 8'hC3},
		'{1'b1, 1'b0, 16'h00FF, 8'h00}};
	cbh_bus_ctrl u_dut (.core_clk_in(clk), .arst_n_in(rst_n), .phase1_in(ph1),
		.phase2_in(ph2), .halt_n_in(halt_n), .bus_float_control_in(float_req),
		.data_drive_enable_in(drv_en), .irq_n_in(irq_n), .address_lines_out(addr),
		.address_lines_oe_out(addr_oe), .data_lines_in(din), .data_lines_out(dout),
		.data_lines_oe_out(dout_oe), .read_write_out(rw), .read_write_oe_out(rw_oe),
		.valid_address_strobe_out(strobe), .bus_released_out(released),
		.core_access_in(acc), .core_write_in(wr), .core_addr_in(caddr),
		.core_wdata_in(cwdata), .core_instr_end_in(iend), .core_irq_ack_in(iack),
		.core_stall_out(stall), .core_rdata_out(rdata), .core_irq_out(cirq),
		.bus_state_out(st), .halt_setup_err_out(serr), .float_overstay_out(over));
	cbh_sys_model u_sys (.core_clk_in(clk), .float_req_in(float_req), .addr_in(addr),
		.addr_oe_in(addr_oe), .rw_in(rw), .phase1_out(ph1), .phase2_out(ph2),
		.drv_en_out(drv_en), .data_out(din));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic chk(input logic ok, input string msg);
		comparisons++;
		if (ok !== 1'b1) begin
			err_count++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask
	// bounded wait for a bus state
	task automatic wait_st(input cbh_state_t s);
		int n;
		n = 0;
		while (st !== s && n < 200) begin
			@(negedge clk);
			n++;
		end
		chk(st === s, "state not reached");
	endtask
	task automatic step_end();
		repeat (24) @(negedge clk);
		iend = 1'b1;
		@(negedge clk);
		iend = 1'b0;
	endtask
	task final_report;
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// watchdog: whole run needs under 2000 cycles
	initial begin
		#100000;
		err_count++;
		final_report;
	end
	initial begin
		{rst_n, acc, wr, iend, iack, float_req} = 6'h00;
		{halt_n, irq_n} = 2'b11;
		caddr = 16'h0000;
		cwdata = 8'h00;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		chk(addr === 16'h0000 && rw === 1'b1 && strobe === 1'b0 && st === CBH_RUN, "reset");
		foreach (rows[i]) begin
			@(posedge ph1);
			{acc, wr, caddr, cwdata} = rows[i];
			repeat (30) @(negedge clk);
			chk(strobe === acc && rw === !(acc && wr), "strobe or direction");
			if (acc) chk(addr === caddr && addr_oe === 1'b1, "address");
			if (acc && wr) chk(dout_oe === 1'b1 && dout === cwdata, "write data");
			if (acc && !wr) chk(dout_oe === 1'b0, "driven on read");
			repeat (12) @(negedge clk);
			if (acc && !wr) chk(rdata === (~caddr[7:0] ^ caddr[15:8]), "read data");
		end
		// halt early in phase one, then finish the instruction
		@(posedge ph1);
		{acc, halt_n} = 2'b00;
		step_end();
		wait_st(CBH_HALTED);
		repeat (3) @(negedge clk);
		chk(released === 1'b1 && strobe === 1'b0 && addr_oe === 1'b0 && rw_oe === 1'b0, "halted");
		irq_n = 1'b0;
		repeat (40) @(negedge clk);
		chk(cirq === 1'b0 && stall === 1'b1, "irq served while halted");
		// one period high runs a single instruction
		@(posedge ph1);
		halt_n = 1'b1;
		@(posedge ph1);
		halt_n = 1'b0;
		chk(st === CBH_RUN && released === 1'b0 && cirq === 1'b1, "single step");
		irq_n = 1'b1;
		step_end();
		wait_st(CBH_HALTED);
		@(posedge ph1);
		halt_n = 1'b1;
		wait_st(CBH_RUN);
		chk(cirq === 1'b1, "latched irq lost after halt");
		iack = 1'b1;
		@(negedge clk);
		iack = 1'b0;
		chk(cirq === 1'b0, "irq not cleared by ack");
		// short float raised at phase one
		@(posedge ph1);
		float_req = 1'b1;
		repeat (4) @(negedge clk);
		chk(addr_oe === 1'b0 && rw_oe === 1'b0 && strobe === 1'b0 && stall === 1'b1, "float");
		repeat (100) @(negedge clk);
		chk(over === 1'b0 && released === 1'b0, "float overstay");
		float_req = 1'b0;
		repeat (4) @(negedge clk);
		chk(addr_oe === 1'b1 && rw_oe === 1'b1 && stall === 1'b0, "float release");
		// float held past its limit must be reported, and cleared once it drops
		@(posedge ph1);
		float_req = 1'b1;
		repeat (190) @(negedge clk);
		chk(over === 1'b1, "overstay not reported");
		float_req = 1'b0;
		repeat (4) @(negedge clk);
		chk(over === 1'b0 && stall === 1'b0, "overstay not cleared");
		// halt glitch late in phase one breaks the quiet window on purpose
		@(posedge ph1);
		repeat (14) @(negedge clk);
		halt_n = 1'b0;
		@(negedge clk);
		halt_n = 1'b1;
		repeat (10) begin
			@(negedge clk);
			if (serr === 1'b1) hits++;
		end
		chk(hits == 1 && st === CBH_RUN, "halt setup error pulse");
		final_report;
	end
endmodule // cbh_bus_ctrl_tb
`default_nettype wire
